// File: rtl/pcl_top.sv
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pcl_defs.svh"
module pcl_top #(
  parameter int N_ACQ = `PCL_N_ACQ_DEF,
  parameter int N_TRK = `PCL_N_TRK_DEF
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // System integration
  input wire logic stop_i,
  input wire logic break_i,
  // Clock sources and analog status
  input wire logic crystal_clock_i,
  input wire logic vco_clock_i,
  input wire logic reference_clock_i,
  input wire logic trk_tol_i,
  input wire logic lock_tol_i,
  // Clock module outputs
  output logic crystal_clock_o,
  output logic module_clock_out_o,
  output logic clock_module_irq_o,
  output logic pll_enable_o,
  output logic pll_track_mode_o
);
  import pcl_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  pcl_lock_if lk ();

  logic ack_r, req, acc, wr, pll_control_reg_acc, flag_clr;
  logic [1:0] idx;
  logic [7:0] rd_nxt, wd;
  logic irq_en_r, pll_change_flag_r, pll_enable_r, base_clock_select_r;
  logic auto_r, acq_man_r, break_clear_enable_r, irq_r;

  // ***************************************************
  // Wishbone slave
  // ***************************************************
  assign req = cyc_i & stb_i & ~ack_r;
  assign acc = cyc_i & stb_i & ack_r;
  assign wr = acc & we_i & sel_i[0];
  assign idx = adr_i[3:2];
  assign wd = dat_i[7:0];
  assign pll_control_reg_acc = acc && idx == `PCL_IDX_PLL_CONTROL_REG && adr_i[1:0] == 2'h0;

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'h0;
    end else begin
      ack_r <= req;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_nxt = 8'h0;
    if (adr_i[1:0] == 2'h0) begin
      unique case (idx)
        `PCL_IDX_PLL_CONTROL_REG: begin
          rd_nxt = {irq_en_r, pll_change_flag_r & auto_r, pll_enable_r,
                    base_clock_select_r, `PCL_PLL_CONTROL_REG_LOW_ONES};
        end
        `PCL_IDX_BANDWIDTH_CONTROL_REG: begin
          rd_nxt[`PCL_BANDWIDTH_CONTROL_REG_AUTO] = auto_r;
          rd_nxt[`PCL_BANDWIDTH_CONTROL_REG_LOCK] = auto_r & lk.lock;
          rd_nxt[`PCL_BANDWIDTH_CONTROL_REG_ACQ] = auto_r ? lk.acq_not : acq_man_r;
        end
        `PCL_IDX_BREAK_FLAG_CONTROL_REG: begin
          rd_nxt[`PCL_BREAK_FLAG_CONTROL_REG_BREAK_CLEAR_ENABLE] = break_clear_enable_r;
        end
        default: rd_nxt = 8'h0;
      endcase
    end
  end

  // Read data captured together with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req) begin
      dat_o <= {24'h0, rd_nxt};
    end
  end

  assign ack_o = ack_r;

  // ***************************************************
  // PLL control register
  // ***************************************************
  // Enable and select guarded by each other's stored value, so one write can clear enable and set select; stop clears select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_enable_r <= `PCL_RST_PLL_ON;
      base_clock_select_r <= `PCL_RST_BCS;
      irq_en_r <= 1'h0;
    end else if (stop_i) begin
      base_clock_select_r <= 1'h0;
    end else if (wr && pll_control_reg_acc) begin
      irq_en_r <= wd[`PCL_PLL_CONTROL_REG_IE];
      pll_enable_r <= wd[`PCL_PLL_CONTROL_REG_ON] | base_clock_select_r;
      base_clock_select_r <= wd[`PCL_PLL_CONTROL_REG_BCS] & pll_enable_r;
    end
  end

  // Flag clear allowed outside break or with break clear enable
  assign flag_clr = pll_control_reg_acc && (!break_i || break_clear_enable_r);

  // Change flag: a lock change in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_change_flag_r <= 1'h0;
    end else if (lk.lock_chg && auto_r) begin
      pll_change_flag_r <= 1'h1;
    end else if (flag_clr || !auto_r) begin
      pll_change_flag_r <= 1'h0;
    end
  end

  // ***************************************************
  // Bandwidth and break flag control registers
  // ***************************************************
  // Mode bit, and stored manual acquisition value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_r <= `PCL_RST_AUTO;
      acq_man_r <= `PCL_RST_ACQ;
    end else if (wr && idx == `PCL_IDX_BANDWIDTH_CONTROL_REG && adr_i[1:0] == 2'h0) begin
      auto_r <= wd[`PCL_BANDWIDTH_CONTROL_REG_AUTO];
      if (!auto_r) begin
        acq_man_r <= wd[`PCL_BANDWIDTH_CONTROL_REG_ACQ];
      end
    end
  end

  // Break clear enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      break_clear_enable_r <= `PCL_RST_BREAK_CLEAR_ENABLE;
    end else if (wr && idx == `PCL_IDX_BREAK_FLAG_CONTROL_REG && adr_i[1:0] == 2'h0) begin
      break_clear_enable_r <= wd[`PCL_BREAK_FLAG_CONTROL_REG_BREAK_CLEAR_ENABLE];
    end
  end

  // ***************************************************
  // Lock detection and clock switching
  // ***************************************************
  assign lk.auto_en = auto_r;
  assign lk.pll_on = pll_enable_r;
  assign lk.stop = stop_i;

  pcl_lock_det #(
    .N_ACQ(N_ACQ),
    .N_TRK(N_TRK)
  ) u_lock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ref_i(reference_clock_i),
    .trk_tol_i(trk_tol_i),
    .lock_tol_i(lock_tol_i),
    .lk(lk.det)
  );

  pcl_clk_switch u_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .xtal_i(crystal_clock_i),
    .vco_i(vco_clock_i),
    .sel_i(base_clock_select_r),
    .stop_i(stop_i),
    .xtal_o(crystal_clock_o),
    .mout_o(module_clock_out_o)
  );

  // ***************************************************
  // Outputs to analog and processor
  // ***************************************************
  // Interrupt: not gated by wait or by the select bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= pll_change_flag_r & irq_en_r & auto_r & ~stop_i;
    end
  end

  assign clock_module_irq_o = irq_r;
  assign pll_enable_o = pll_enable_r;
  assign pll_track_mode_o = auto_r ? lk.acq_not : acq_man_r;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_stop_outs_low: assert property (stop_i |=>
    !module_clock_out_o && !crystal_clock_o && !clock_module_irq_o)
    else $error("outputs not low during stop");
  a_stop_clr_sel: assert property (stop_i |=> !base_clock_select_r)
    else $error("select not cleared by stop");
  a_sel_needs_on: assert property (base_clock_select_r |-> pll_enable_r)
    else $error("select set with pll off");
  a_flag_kept_brk: assert property (
    pll_change_flag_r && auto_r && break_i && !break_clear_enable_r
    && !stop_i ##1 auto_r |-> pll_change_flag_r)
    else $error("change flag lost in protected break");
  a_flag_clr_read: assert property (
    pll_control_reg_acc && !break_i && !(lk.lock_chg && auto_r) |=> !pll_change_flag_r)
    else $error("control access did not clear flag");
  a_flag_clr_brk: assert property (
    pll_control_reg_acc && break_i && break_clear_enable_r && !lk.lock_chg
    |=> !pll_change_flag_r ##1 (!pll_change_flag_r || $past(lk.lock_chg)))
    else $error("break clear not taken or not kept");
  a_flag_set_wins: assert property (
    lk.lock_chg && auto_r |=> pll_change_flag_r)
    else $error("lock change lost");
  a_irq_in_wait: assert property (
    pll_change_flag_r && irq_en_r && auto_r && !stop_i |=> clock_module_irq_o)
    else $error("interrupt not raised");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
endmodule

// File: rtl/pcl_defs.svh
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

// ***************************************************
// Register word indexes (byte address = index * 4)
// ***************************************************
`define PCL_IDX_PLL_CONTROL_REG 2'h0
`define PCL_IDX_BANDWIDTH_CONTROL_REG 2'h1
`define PCL_IDX_BREAK_FLAG_CONTROL_REG 2'h2

// ***************************************************
// Field positions
// ***************************************************
`define PCL_PLL_CONTROL_REG_IE 7
`define PCL_PLL_CONTROL_REG_FLAG 6
`define PCL_PLL_CONTROL_REG_ON 5
`define PCL_PLL_CONTROL_REG_BCS 4
`define PCL_PLL_CONTROL_REG_LOW_ONES 4'hf
`define PCL_BANDWIDTH_CONTROL_REG_AUTO 7
`define PCL_BANDWIDTH_CONTROL_REG_LOCK 6
`define PCL_BANDWIDTH_CONTROL_REG_ACQ 5
`define PCL_BREAK_FLAG_CONTROL_REG_BREAK_CLEAR_ENABLE 7

// ***************************************************
// Reset values
// ***************************************************
`define PCL_RST_PLL_ON 1'h1
`define PCL_RST_BCS 1'h0
`define PCL_RST_AUTO 1'h0
`define PCL_RST_ACQ 1'h0
`define PCL_RST_BREAK_CLEAR_ENABLE 1'h0

// ***************************************************
// Timing counts
// ***************************************************
`define PCL_SW_EDGES 2'h3
`define PCL_N_ACQ_DEF 8
`define PCL_N_TRK_DEF 16

`endif

// File: rtl/pcl_pkg.sv
package pcl_pkg;
  // Clock switch sequence
  typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_FILL} pcl_sw_state_type;
  // Lock detector phase
  typedef enum logic [1:0] {LD_ACQ, LD_TRK, LD_LOCK} pcl_ld_state_type;
endpackage

// File: rtl/pcl_lock_if.sv
`timescale 1ns/100ps
// Control into and status out of the lock detector
interface pcl_lock_if;
  logic auto_en;
  logic pll_on;
  logic stop;
  logic acq_not;
  logic lock;
  logic lock_chg;
  modport ctl (output auto_en, pll_on, stop, input acq_not, lock, lock_chg);
  modport det (input auto_en, pll_on, stop, output acq_not, lock, lock_chg);
endinterface

// File: rtl/pcl_clk_switch.sv
`timescale 1ns/100ps
`include "pcl_defs.svh"
module pcl_clk_switch (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Source clocks and control
  input wire logic xtal_i,
  input wire logic vco_i,
  input wire logic sel_i,
  input wire logic stop_i,
  // Outputs
  output logic xtal_o,
  output logic mout_o
);
  import pcl_pkg::*;

  logic x_s1_r, x_s2_r, x_s3_r, v_s1_r, v_s2_r, v_s3_r;
  logic xe, ve, old_e, new_e, cur_r, div_r;
  logic [1:0] cnt_r;
  pcl_sw_state_type st_r;

  // Two-flop synchronisers per source, third flop for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {x_s1_r, x_s2_r, x_s3_r} <= 3'h0;
      {v_s1_r, v_s2_r, v_s3_r} <= 3'h0;
    end else begin
      {x_s1_r, x_s2_r, x_s3_r} <= {xtal_i, x_s1_r, x_s2_r};
      {v_s1_r, v_s2_r, v_s3_r} <= {vco_i, v_s1_r, v_s2_r};
    end
  end

  assign xe = x_s2_r & ~x_s3_r;
  assign ve = v_s2_r & ~v_s3_r;
  assign old_e = cur_r ? ve : xe;
  assign new_e = cur_r ? xe : ve;

  // Source selection, stasis while switching, divide by two
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_i) begin
      st_r <= SW_RUN;
      cur_r <= 1'h0;
      cnt_r <= 2'h0;
      div_r <= 1'h0;
    end else begin
      unique case (st_r)
        SW_RUN: begin
          cnt_r <= 2'h0;
          if (sel_i != cur_r) begin
            st_r <= SW_DRAIN;
          end else if (old_e) begin
            div_r <= ~div_r;
          end
        end
        SW_DRAIN: begin
          if (old_e) begin
            cnt_r <= cnt_r + 2'h1;
          end
          if (cnt_r == `PCL_SW_EDGES) begin
            cnt_r <= 2'h0;
            st_r <= SW_FILL;
          end
        end
        SW_FILL: begin
          if (new_e) begin
            cnt_r <= cnt_r + 2'h1;
          end
          if (cnt_r == `PCL_SW_EDGES) begin
            cur_r <= sel_i;
            st_r <= SW_RUN;
          end
        end
      endcase
    end
  end

  // Crystal level out, held low in stop
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_i) begin
      xtal_o <= 1'h0;
    end else begin
      xtal_o <= x_s2_r;
    end
  end

  assign mout_o = div_r;

  // ***************************************************
  // Checks
  // ***************************************************
  a_out_stasis: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r != SW_RUN && !stop_i) |=> $stable(div_r))
    else $error("module clock changed during source switch");
endmodule

// File: rtl/pcl_lock_det.sv
`timescale 1ns/100ps
`include "pcl_defs.svh"
module pcl_lock_det #(
  parameter int N_ACQ = `PCL_N_ACQ_DEF,
  parameter int N_TRK = `PCL_N_TRK_DEF
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Reference clock and tolerance comparators
  input wire logic ref_i,
  input wire logic trk_tol_i,
  input wire logic lock_tol_i,
  // Control and status
  pcl_lock_if.det lk
);
  import pcl_pkg::*;

  logic r_s1_r, r_s2_r, r_s3_r, edge_w, active, wend, ok_trk, ok_lock;
  logic ok_trk_r, ok_lock_r, win_end_q;
  logic [15:0] cnt_r, len;
  pcl_ld_state_type st_r;

  // Reference clock synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {r_s1_r, r_s2_r, r_s3_r} <= 3'h0;
    end else begin
      {r_s1_r, r_s2_r, r_s3_r} <= {ref_i, r_s1_r, r_s2_r};
    end
  end

  assign edge_w = r_s2_r & ~r_s3_r;
  assign active = lk.auto_en & lk.pll_on & ~lk.stop;
  assign len = (st_r == LD_ACQ) ? 16'(N_ACQ) : 16'(N_TRK);
  assign wend = edge_w && (cnt_r == len - 16'h1);
  assign ok_trk = ok_trk_r & trk_tol_i;
  assign ok_lock = ok_lock_r & lock_tol_i;

  // Window counting and phase decisions at window ends only
  always_ff @(posedge clk_i) begin
    if (rst_i || !active) begin
      st_r <= LD_ACQ;
      cnt_r <= 16'h0;
      ok_trk_r <= 1'h1;
      ok_lock_r <= 1'h1;
    end else if (wend) begin
      cnt_r <= 16'h0;
      ok_trk_r <= 1'h1;
      ok_lock_r <= 1'h1;
      unique case (st_r)
        LD_ACQ: if (ok_trk) st_r <= LD_TRK;
        LD_TRK: begin
          if (!ok_trk) st_r <= LD_ACQ;
          else if (ok_lock) st_r <= LD_LOCK;
        end
        LD_LOCK: begin
          if (!ok_trk) st_r <= LD_ACQ;
          else if (!ok_lock) st_r <= LD_TRK;
        end
      endcase
    end else if (edge_w) begin
      cnt_r <= cnt_r + 16'h1;
      ok_trk_r <= ok_trk;
      ok_lock_r <= ok_lock;
    end
  end

  // Status flops and lock change pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk.acq_not <= 1'h0;
      lk.lock <= 1'h0;
      lk.lock_chg <= 1'h0;
      win_end_q <= 1'h0;
    end else begin
      lk.acq_not <= active && st_r != LD_ACQ;
      lk.lock <= active && st_r == LD_LOCK;
      lk.lock_chg <= active && (lk.lock != (st_r == LD_LOCK));
      win_end_q <= wend;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  a_lock_on_window: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(lk.lock) |-> $past(win_end_q))
    else $error("lock rose outside a window boundary");
  a_lock_needs_trk: assert property (@(posedge clk_i) disable iff (rst_i)
    lk.lock |-> lk.acq_not)
    else $error("lock set while still acquiring");
endmodule

// File: verification/pcl_far_model.sv
`timescale 1ns/100ps
// *********************************************
// Far side: source clocks and loop comparators
// *********************************************
module pcl_far_model (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Loop control
  input wire logic pll_on_i,
  input wire logic settled_i,
  // Sources and comparators
  output logic xtal_o,
  output logic vco_o,
  output logic ref_o,
  output logic trk_tol_o,
  output logic lock_tol_o
);
  int cnt_r;

  // Free running phase counter
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_r == 119) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end

  // Crystal 8, VCO 6, reference 10 cycles; VCO dead with loop off
  assign xtal_o = (cnt_r % 8) < 4;
  assign vco_o = pll_on_i && (cnt_r % 6) < 3;
  assign ref_o = (cnt_r % 10) < 5;
  // Comparators report a settled loop only while it is powered
  assign trk_tol_o = pll_on_i && settled_i;
  assign lock_tol_o = pll_on_i && settled_i;
endmodule

// File: verification/pcl_top_bench.sv
`timescale 1ns/100ps
// *****************************************
// Bench for the clock control block
// *****************************************
module pcl_top_bench;
  localparam int NA = 2;
  localparam int NT = 3;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, stop_i, break_i, settled;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd, d;
  logic ack_o, xt, vc, rf, trk, lck, xo, mo, irq, pon, tm;
  int num_errors, checks_done, seed, n, i;

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  pcl_top #(.N_ACQ(NA), .N_TRK(NT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .stop_i(stop_i), .break_i(break_i),
    .crystal_clock_i(xt), .vco_clock_i(vc), .reference_clock_i(rf),
    .trk_tol_i(trk), .lock_tol_i(lck), .crystal_clock_o(xo),
    .module_clock_out_o(mo), .clock_module_irq_o(irq),
    .pll_enable_o(pon), .pll_track_mode_o(tm)
  );

  pcl_far_model far (
    .clk_i(clk_i), .rst_i(rst_i), .pll_on_i(pon), .settled_i(settled),
    .xtal_o(xt), .vco_o(vc), .ref_o(rf), .trk_tol_o(trk),
    .lock_tol_o(lck)
  );

  // Verdict and end of run
  task close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Value comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Cycle count comparison
  task chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("BAD t=%0t got=%h lim=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Wishbone single cycle, entered just after a rising edge
  task wb(input logic w, input logic [3:0] a, input logic [7:0] v,
          input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, v};
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Register read with expected value
  task rdc(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 8'h00, 4'hf);
    chk(rd, exp);
  endtask

  // Cycles until irq (or tracking mode) rises
  task wt(input bit sel_irq, output int c);
    c = 0;
    while ((sel_irq ? irq : tm) !== 1'b1) begin
      @(posedge clk_i);
      c++;
    end
  endtask

  // Period of the module clock in system cycles
  task meas(output int p);
    while (mo !== 1'b0) @(posedge clk_i);
    while (mo !== 1'b1) @(posedge clk_i);
    p = 0;
    while (mo !== 1'b0) begin
      @(posedge clk_i);
      p++;
    end
    while (mo !== 1'b1) begin
      @(posedge clk_i);
      p++;
    end
  endtask

  // All clock outputs and irq held low through stop
  task stop_chk;
    stop_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    d = 0;
    for (i = 0; i < 40; i++) begin
      d[0] = d[0] | xo | mo | irq;
      @(posedge clk_i);
    end
    stop_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Watchdog
  initial begin
    #400000;
    num_errors++;
    close_out;
  end

  // Main sequence
  initial begin
    seed = 32'h49086c32;
    num_errors = 0;
    checks_done = 0;
    {cyc_i, stb_i, we_i, stop_i, break_i, settled} = 6'h00;
    adr_i = 4'h0;
    sel_i = 4'h0;
    dat_i = 32'h0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(4'h0, 32'h2f);
    rdc(4'h4, 32'h0);
    rdc(4'h8, 32'h0);
    // Random control writes and unmapped accesses
    for (n = 0; n < 6; n++) begin
      d = $random(seed);
      wb(1'b1, 4'h8, d[7:0], {d[11:9], 1'b1});
      rdc(4'h8, {24'h0, d[7], 7'h0});
      wb(1'b1, {2'h3, d[13:12]}, d[7:0], 4'hf);
      rdc({2'h3, d[13:12]}, 32'h0);
    end
    wb(1'b1, 4'h8, 8'h00, 4'hf);
    wb(1'b1, 4'h8, 8'h80, 4'he);
    rdc(4'h8, 32'h0);
    meas(n);
    chk_rng(n, 16, 16);
    // Loop off first, select refused, then two writes
    wb(1'b1, 4'h0, 8'h00, 4'hf);
    wb(1'b1, 4'h0, 8'h10, 4'hf);
    rdc(4'h0, 32'h0f);
    wb(1'b1, 4'h0, 8'h20, 4'hf);
    repeat (300) @(posedge clk_i);
    wb(1'b1, 4'h0, 8'h30, 4'hf);
    rdc(4'h0, 32'h3f);
    meas(n);
    chk_rng(n, 12, 12);
    stop_chk;
    chk(d, 32'h0);
    rdc(4'h0, 32'h2f);
    meas(n);
    chk_rng(n, 16, 16);
    // Automatic mode acquisition and lock
    wb(1'b1, 4'h0, 8'ha0, 4'hf);
    settled <= 1'b1;
    wb(1'b1, 4'h4, 8'h80, 4'hf);
    wt(1'b0, n);
    chk_rng(n, (NA - 1) * 10, (NA + 1) * 10 + 12);
    wt(1'b1, n);
    chk_rng(n, (NT - 1) * 10, (NT + 1) * 10 + 12);
    rdc(4'h4, 32'he0);
    // Protected break keeps the change flag
    break_i <= 1'b1;
    rdc(4'h0, 32'hef);
    rdc(4'h0, 32'hef);
    break_i <= 1'b0;
    rdc(4'h0, 32'hef);
    rdc(4'h0, 32'haf);
    chk(irq, 1'b0);
    // Lock loss, then clears allowed in break
    settled <= 1'b0;
    wt(1'b1, n);
    wb(1'b1, 4'h8, 8'h80, 4'hf);
    break_i <= 1'b1;
    rdc(4'h0, 32'hef);
    rdc(4'h0, 32'haf);
    break_i <= 1'b0;
    rdc(4'h0, 32'haf);
    // Relock, then stop silences the pending irq
    settled <= 1'b1;
    wt(1'b1, n);
    stop_chk;
    chk(d, 32'h0);
    close_out;
  end
endmodule
